// ---- rtl/sle_defines.vh ----
// constants of the sequential logic equation engine
// assumes the includer owns the clock and the ahb-lite slave port
`ifndef SLE_DEFINES_VH
`define SLE_DEFINES_VH
// register byte offsets
`define SLE_CTRL 12'h000
`define SLE_STAT 12'h004
`define SLE_PCNT 12'h008
`define SLE_VOUT 12'h00C
`define SLE_VIN 12'h010
`define SLE_CIN 12'h014
`define SLE_TDLY 12'h018
`define SLE_COSEL 12'h01C
`define SLE_BSEL 12'h020
`define SLE_E0CFG 12'h024
`define SLE_E1CFG 12'h028
`define SLE_E0DLY 12'h02C
`define SLE_E1DLY 12'h030
// program words sit where this address bit is set
`define SLE_PROG_BIT 10
// field positions
`define SLE_CTRL_EN 0
`define SLE_CTRL_GO 1
`define SLE_STAT_BUSY 0
`define SLE_STAT_OVR 1
`define SLE_CFG_FALL 16
// reset values
`define SLE_TDLY_RST 32'h00000000
`define SLE_COSEL_RST 32'h00000000
`define SLE_CFG_RST 17'h0FFFF
`define SLE_DLY_RST 16'h0000
// instruction opcodes
`define SLE_OP_END 4'h0
`define SLE_OP_LD 4'h1
`define SLE_OP_LDN 4'h2
`define SLE_OP_AND 4'h3
`define SLE_OP_ANDN 4'h4
`define SLE_OP_OR 4'h5
`define SLE_OP_ORN 4'h6
`define SLE_OP_XOR 4'h7
`define SLE_OP_RST 4'h8
`define SLE_OP_LAT 4'h9
`define SLE_OP_TMR 4'hA
`define SLE_OP_OUT 4'hB
// pacing
`define SLE_CLK_HZ 25000000
`define SLE_SYS_HZ 60
`define SLE_PASSES 4
`endif

// ---- rtl/sle_mem.v ----
// program store of the equation engine, one instruction per word
// assumes one write port from the bus and one read port from the engine
`timescale 1ns/1ns
module sle_mem #(
   parameter P_AW = 8,
   parameter P_DW = 11
) (
   input wire i_clk,
   input wire i_we,
   input wire [P_AW-1:0] i_waddr,
   input wire [P_DW-1:0] i_wdata,
   input wire [P_AW-1:0] i_raddr,
   output reg [P_DW-1:0] o_rdata
);
   reg [P_DW-1:0] mem_reg [0:(1<<P_AW)-1];

   // contents undefined until software loads them
   always @(posedge i_clk) begin
      if (i_we) begin
         mem_reg[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_reg[i_raddr];
   end
endmodule

// ---- rtl/sle_elem.v ----
// one protection element: comparator, operate and reset timers
// assumes i_tick pulses once per evaluation pass
`timescale 1ns/1ns
module sle_elem #(
   parameter P_QW = 16,
   parameter P_TW = 8
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_tick,
   input wire [P_QW-1:0] i_qty,
   input wire [P_QW-1:0] i_set,
   input wire i_falling,
   input wire [P_TW-1:0] i_op_dly,
   input wire [P_TW-1:0] i_rst_dly,
   input wire i_force_blk,
   input wire i_blk_in,
   output wire o_pkp,
   output wire o_dpo,
   output wire o_op,
   output wire o_blk
);
   reg pkp_reg;
   reg op_reg;
   reg [P_TW-1:0] pcnt_reg;
   reg [P_TW-1:0] rcnt_reg;
   wire above;

   assign above = i_falling ? (i_qty < i_set) : (i_qty > i_set);
   assign o_blk = i_force_blk | i_blk_in;
   assign o_pkp = pkp_reg;
   assign o_dpo = ~pkp_reg;
   assign o_op = op_reg;

   // comparator; a blocked element never picks up
   always @(posedge i_clk) begin
      if (i_rst) begin
         pkp_reg <= 1'b0;
      end else begin
         pkp_reg <= above & ~o_blk;
      end
   end

   // operate after pickup delay, hold until reset delay runs out
   always @(posedge i_clk) begin
      if (i_rst) begin
         op_reg <= 1'b0;
         pcnt_reg <= {P_TW{1'b0}};
         rcnt_reg <= {P_TW{1'b0}};
      end else if (i_tick) begin
         if (pkp_reg) begin
            rcnt_reg <= {P_TW{1'b0}};
            if (pcnt_reg >= i_op_dly) begin
               op_reg <= 1'b1;
            end else begin
               pcnt_reg <= pcnt_reg + 1'b1;
            end
         end else begin
            pcnt_reg <= {P_TW{1'b0}};
            if (op_reg) begin
               if (rcnt_reg >= i_rst_dly) begin
                  op_reg <= 1'b0;
                  rcnt_reg <= {P_TW{1'b0}};
               end else begin
                  rcnt_reg <= rcnt_reg + 1'b1;
               end
            end
         end
      end
   end
endmodule

// ---- rtl/sle_top.v ----
// sequential logic equation engine with ahb-lite register slave
// assumes inputs synchronous to i_clk and a single ahb-lite master
`timescale 1ns/1ns
`include "sle_defines.vh"
module sle_top #(
   parameter P_PASS_CYCLES =
      `SLE_CLK_HZ / (`SLE_SYS_HZ * `SLE_PASSES),
   parameter P_AW = 12,
   parameter P_PW = 8,
   parameter P_NCIN = 8,
   parameter P_NCOUT = 4,
   parameter P_NDIN = 4,
   parameter P_QW = 16
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_hsel,
   input wire [P_AW-1:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg o_hreadyout,
   output reg [31:0] o_hrdata,
   output reg o_hresp,
   input wire [P_NCIN-1:0] i_cin,
   input wire [P_NCOUT-1:0] i_cout_volt,
   input wire [P_NCOUT-1:0] i_cout_curr,
   input wire [P_NDIN-1:0] i_din,
   input wire [2*P_QW-1:0] i_elem_qty,
   input wire [1:0] i_elem_force_blk,
   output reg [15:0] o_vout,
   output reg [7:0] o_vin,
   output reg [P_NCOUT-1:0] o_cout_drive,
   output reg o_pass_done
);
   localparam ST_IDLE = 2'h0;
   localparam ST_FETCH = 2'h1;
   localparam ST_EXEC = 2'h2;

   // pick one operand bit; shared by engine, drives and block routing
   function f_pick;
      input [127:0] vec;
      input [6:0] sel;
      begin
         f_pick = vec[sel];
      end
   endfunction

   reg [1:0] state_reg;
   reg [P_PW-1:0] pc_reg;
   reg acc_reg;
   reg b_reg;
   reg [3:0] lat_reg;
   reg [7:0] tcnt_reg [0:3];
   reg [31:0] pace_reg;
   reg tick_reg;
   reg en_reg;
   reg go_reg;
   reg ovr_reg;
   reg [15:0] pcnt_reg;
   reg [31:0] tdly_reg;
   reg [31:0] cosel_reg;
   reg [15:0] bsel_reg;
   reg [16:0] cfg_reg [0:1];
   reg [15:0] dly_reg [0:1];
   reg [1:0] blk_src_reg;
   reg dp_wr_reg;
   reg [P_AW-1:0] dp_addr_reg;
   reg [31:0] rd_next;
   integer i, j;

   wire [10:0] instr;
   wire [3:0] opc;
   wire [6:0] sel;
   wire opbit;
   wire [7:0] tcur;
   wire [7:0] tdly;
   wire start;
   wire ap_take;
   wire prog_we;
   wire [1:0] pickup_flag;
   wire [1:0] dropout_flag;
   wire [1:0] opf;
   wire [1:0] block_flag;
   wire [127:0] opnd;

   // flag space: every operand is one bit, index is the operand number
   assign opnd = {58'h0, o_vout, o_vin, block_flag, opf, dropout_flag, pickup_flag,
                  i_din,
                  ~i_cout_curr, i_cout_curr,
                  ~i_cout_volt, i_cout_volt,
                  ~i_cin, i_cin,
                  1'b1, 1'b0};

   assign opc = instr[10:7];
   assign sel = instr[6:0];
   assign opbit = f_pick(opnd, sel);
   assign tcur = tcnt_reg[sel[1:0]];
   assign tdly = tdly_reg[{sel[1:0], 3'h0} +: 8];

   // a pass begins on the pacing tick or on a one-shot request
   assign start = (state_reg == ST_IDLE) & ((en_reg & tick_reg) | go_reg);

   // address phase accepted when selected, nonseq or seq (busy and idle ignored) and bus ready
   assign ap_take = i_hsel & i_htrans[1] & i_hready;
   assign prog_we = dp_wr_reg & dp_addr_reg[`SLE_PROG_BIT];

   sle_mem #(
      .P_AW(P_PW),
      .P_DW(11)
   ) u_mem (
      .i_clk(i_clk),
      .i_we(prog_we),
      .i_waddr(dp_addr_reg[P_PW+1:2]),
      .i_wdata(i_hwdata[10:0]),
      .i_raddr(pc_reg),
      .o_rdata(instr)
   );

   // two elements; quantity, setting and timers per element
   genvar e;
   generate
      for (e = 0; e < 2; e = e + 1) begin : g_elem
         sle_elem #(
            .P_QW(P_QW),
            .P_TW(8)
         ) u_elem (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_tick(o_pass_done),
            .i_qty(i_elem_qty[e*P_QW +: P_QW]),
            .i_set(cfg_reg[e][P_QW-1:0]),
            .i_falling(cfg_reg[e][`SLE_CFG_FALL]),
            .i_op_dly(dly_reg[e][7:0]),
            .i_rst_dly(dly_reg[e][15:8]),
            .i_force_blk(i_elem_force_blk[e]),
            .i_blk_in(blk_src_reg[e]),
            .o_pkp(pickup_flag[e]),
            .o_dpo(dropout_flag[e]),
            .o_op(opf[e]),
            .o_blk(block_flag[e])
         );
      end
   endgenerate

   // pacing counter; period is a quarter system cycle at most
   always @(posedge i_clk) begin
      if (i_rst) begin
         pace_reg <= 32'h00000000;
         tick_reg <= 1'b0;
      end else if (pace_reg >= P_PASS_CYCLES - 1) begin
         pace_reg <= 32'h00000000;
         tick_reg <= 1'b1;
      end else begin
         pace_reg <= pace_reg + 32'h00000001;
         tick_reg <= 1'b0;
      end
   end

   // engine: fetch then execute, one instruction at a time
   always @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         pc_reg <= {P_PW{1'b0}};
         acc_reg <= 1'b0;
         b_reg <= 1'b0;
         lat_reg <= 4'h0;
         o_vout <= 16'h0000;
         o_pass_done <= 1'b0;
         pcnt_reg <= 16'h0000;
         for (i = 0; i < 4; i = i + 1) begin
            tcnt_reg[i] <= 8'h00;
         end
      end else begin
         o_pass_done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  pc_reg <= {P_PW{1'b0}};
                  acc_reg <= 1'b0;
                  state_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               state_reg <= ST_EXEC;
            end
            ST_EXEC: begin
               pc_reg <= pc_reg + 1'b1;
               state_reg <= ST_FETCH;
               case (opc)
                  `SLE_OP_LD: acc_reg <= opbit;
                  `SLE_OP_LDN: acc_reg <= ~opbit;
                  `SLE_OP_AND: acc_reg <= acc_reg & opbit;
                  `SLE_OP_ANDN: acc_reg <= acc_reg & ~opbit;
                  `SLE_OP_OR: acc_reg <= acc_reg | opbit;
                  `SLE_OP_ORN: acc_reg <= acc_reg | ~opbit;
                  `SLE_OP_XOR: acc_reg <= acc_reg ^ opbit;
                  `SLE_OP_RST: b_reg <= acc_reg;
                  `SLE_OP_LAT: begin
                     // reset input dominates a simultaneous set
                     lat_reg[sel[1:0]] <=
                        ~b_reg & (acc_reg | lat_reg[sel[1:0]]);
                     acc_reg <= ~b_reg & (acc_reg | lat_reg[sel[1:0]]);
                  end
                  `SLE_OP_TMR: begin
                     // timer counts passes while its input holds
                     if (!acc_reg) begin
                        tcnt_reg[sel[1:0]] <= 8'h00;
                     end else if (tcur < tdly) begin
                        tcnt_reg[sel[1:0]] <= tcur + 8'h01;
                     end
                     acc_reg <= acc_reg & (tcur >= tdly);
                  end
                  `SLE_OP_OUT: begin
                     // only writer of the virtual outputs
                     o_vout[sel[3:0]] <= acc_reg;
                  end
                  default: begin
                     // end of program closes the pass
                     state_reg <= ST_IDLE;
                     o_pass_done <= 1'b1;
                     pcnt_reg <= pcnt_reg + 16'h0001;
                  end
               endcase
               if (pc_reg == {P_PW{1'b1}}) begin
                  // last word ends the pass even without END
                  state_reg <= ST_IDLE;
                  o_pass_done <= 1'b1;
                  pcnt_reg <= pcnt_reg + 16'h0001;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // routed flags: contact drives and element blocking inputs
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_cout_drive <= {P_NCOUT{1'b0}};
         blk_src_reg <= 2'h0;
      end else begin
         for (j = 0; j < P_NCOUT; j = j + 1) begin
            o_cout_drive[j] <= f_pick(opnd, cosel_reg[j*8 +: 7]);
         end
         // registered so a block flag routed to itself cannot loop
         blk_src_reg[0] <= bsel_reg[7] & f_pick(opnd, bsel_reg[6:0]);
         blk_src_reg[1] <= bsel_reg[15] & f_pick(opnd, bsel_reg[14:8]);
      end
   end

   // ahb-lite: zero wait states, always okay
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h00000000;
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= {P_AW{1'b0}};
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         dp_wr_reg <= ap_take & i_hwrite;
         if (ap_take) begin
            dp_addr_reg <= i_haddr;
            o_hrdata <= i_hwrite ? 32'h00000000 : rd_next;
         end
      end
   end

   // read mux; program words and unmapped addresses read zero
   always @* begin
      rd_next = 32'h00000000;
      if (!i_haddr[`SLE_PROG_BIT]) begin
         case ({i_haddr[P_AW-1:2], 2'h0})
            `SLE_CTRL: rd_next = {31'h0, en_reg};
            `SLE_STAT: rd_next = {30'h0, ovr_reg, state_reg != ST_IDLE};
            `SLE_PCNT: rd_next = {16'h0, pcnt_reg};
            `SLE_VOUT: rd_next = {16'h0, o_vout};
            `SLE_VIN: rd_next = {24'h0, o_vin};
            `SLE_CIN: rd_next = {24'h0, i_cin};
            `SLE_TDLY: rd_next = tdly_reg;
            `SLE_COSEL: rd_next = cosel_reg;
            `SLE_BSEL: rd_next = {16'h0, bsel_reg};
            `SLE_E0CFG: rd_next = {15'h0, cfg_reg[0]};
            `SLE_E1CFG: rd_next = {15'h0, cfg_reg[1]};
            `SLE_E0DLY: rd_next = {16'h0, dly_reg[0]};
            `SLE_E1DLY: rd_next = {16'h0, dly_reg[1]};
            default: rd_next = 32'h00000000;
         endcase
      end
   end

   // register writes in the data phase
   always @(posedge i_clk) begin
      if (i_rst) begin
         en_reg <= 1'b0;
         go_reg <= 1'b0;
         o_vin <= 8'h00;
         tdly_reg <= `SLE_TDLY_RST;
         cosel_reg <= `SLE_COSEL_RST;
         bsel_reg <= 16'h0000;
         cfg_reg[0] <= `SLE_CFG_RST;
         cfg_reg[1] <= `SLE_CFG_RST;
         dly_reg[0] <= `SLE_DLY_RST;
         dly_reg[1] <= `SLE_DLY_RST;
      end else begin
         // one-shot request waits until the engine is idle
         if (start) begin
            go_reg <= 1'b0;
         end
         if (dp_wr_reg && !dp_addr_reg[`SLE_PROG_BIT]) begin
            case ({dp_addr_reg[P_AW-1:2], 2'h0})
               `SLE_CTRL: begin
                  en_reg <= i_hwdata[`SLE_CTRL_EN];
                  if (i_hwdata[`SLE_CTRL_GO]) begin
                     go_reg <= 1'b1;
                  end
               end
               `SLE_VIN: o_vin <= i_hwdata[7:0];
               `SLE_TDLY: tdly_reg <= i_hwdata;
               `SLE_COSEL: cosel_reg <= i_hwdata;
               `SLE_BSEL: bsel_reg <= i_hwdata[15:0];
               `SLE_E0CFG: cfg_reg[0] <= i_hwdata[16:0];
               `SLE_E1CFG: cfg_reg[1] <= i_hwdata[16:0];
               `SLE_E0DLY: dly_reg[0] <= i_hwdata[15:0];
               `SLE_E1DLY: dly_reg[1] <= i_hwdata[15:0];
               default: begin
               end
            endcase
         end
      end
   end

   // overrun: pacing tick while a pass still runs; set beats clear
   always @(posedge i_clk) begin
      if (i_rst) begin
         ovr_reg <= 1'b0;
      end else if (en_reg && tick_reg && state_reg != ST_IDLE) begin
         ovr_reg <= 1'b1;
      end else if (dp_wr_reg && !dp_addr_reg[`SLE_PROG_BIT] &&
                   {dp_addr_reg[P_AW-1:2], 2'h0} == `SLE_STAT &&
                   i_hwdata[`SLE_STAT_OVR]) begin
         ovr_reg <= 1'b0;
      end
   end
endmodule

// ---- tb/sle_top_monitor.sv ----
// concurrent checks on the bus and flag ports of the equation engine
// assumes one clock and a synchronous active high reset, bound to sle_top
`timescale 1ns/1ns
`include "sle_defines.vh"
module sle_top_monitor #(
   parameter P_AW = 12
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_hsel,
   input wire [P_AW-1:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   input wire o_hreadyout,
   input wire [31:0] o_hrdata,
   input wire o_hresp,
   input wire [15:0] o_vout,
   input wire [7:0] o_vin,
   input wire o_pass_done
);
   logic take;
   logic rd_zero_q, rd_vout_q, rd_vin_q, wr_vin_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   assign take = i_hsel && i_htrans[1] && i_hready;
   // what the accepted address phase asked for, kept for its data phase
   always @(posedge i_clk) begin
      if (i_rst) begin
         rd_zero_q <= 1'b0;
         rd_vout_q <= 1'b0;
         rd_vin_q <= 1'b0;
         wr_vin_q <= 1'b0;
      end else begin
         rd_zero_q <= take && !i_hwrite && i_haddr > `SLE_E1DLY;
         rd_vout_q <= take && !i_hwrite && i_haddr == `SLE_VOUT;
         rd_vin_q <= take && !i_hwrite && i_haddr == `SLE_VIN;
         wr_vin_q <= take && i_hwrite && i_haddr == `SLE_VIN;
      end
   end
   a_bus_okay: assert property (take |=> o_hreadyout && !o_hresp)
      else $error("bus answer not ready or not okay");
   a_rd_zero: assert property (rd_zero_q |-> o_hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_vout_read: assert property (
      rd_vout_q |-> o_hrdata == {16'h0, $past(o_vout)})
      else $error("virtual output readback wrong");
   a_vin_read: assert property (
      rd_vin_q |-> o_hrdata == {24'h0, $past(o_vin)})
      else $error("virtual input readback wrong");
   a_vin_write: assert property (
      wr_vin_q |=> o_vin == $past(i_hwdata[7:0]))
      else $error("virtual input write lost");
   a_vin_source: assert property ($changed(o_vin) |-> $past(wr_vin_q))
      else $error("virtual input changed without write");
   a_vout_source: assert property (
      $changed(o_vout) |-> ##[0:520] o_pass_done)
      else $error("virtual output changed outside a pass");
   a_done_pulse: assert property (o_pass_done |=> !o_pass_done)
      else $error("pass done longer than one cycle");
   a_hrdata_hold: assert property (!take |=> $stable(o_hrdata))
      else $error("read data moved without request");
endmodule

// ---- tb/sle_contact_model.sv ----
// field side of the contact outputs: wetting supply and load per contact
// assumes drive is the engine's contact command, one bit per contact
`timescale 1ns/1ns
module sle_contact_model #(
   parameter int P_N = 4
) (
   input wire logic i_clk,
   input wire logic [P_N-1:0] i_drive,
   input wire logic [P_N-1:0] i_wet,
   input wire logic [P_N-1:0] i_load,
   output logic [P_N-1:0] o_volt = '0,
   output logic [P_N-1:0] o_curr = '0
);
   // open contact shows supply, closed one carries load; sense lags a cycle
   always @(posedge i_clk) begin
      o_volt <= i_wet & ~i_drive;
      o_curr <= i_load & i_drive;
   end
endmodule

// ---- tb/sle_top_tb_top.sv ----
// testbench of the equation engine: program load, random passes, pacing
// assumes design, contact model and monitor files are compiled first
`timescale 1ns/1ns
`include "sle_defines.vh"
module sle_top_tb_top;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, lat = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0, fblk = 2'h0;
   logic [31:0] hwdata = 32'h0, qty = 32'h0, seed = 32'h73DDD8DF;
   logic [31:0] rd, hrdata;
   logic hready, hresp, done, eop = 1'b0;
   logic [7:0] cin = 8'h00, vin, v;
   logic [3:0] din = 4'h0, wet = 4'h0, load = 4'h0, volt, curr, drv;
   logic [15:0] vout, ev = 16'h0;
   int tcnt = 0, num_errors = 0, cmp_count = 0, cyc = 0, dcnt = 0, n;
   // element 0 operate model: pickup and reset delays of one pass each
   int epc = 0, erc = 0;
   logic [11:0] ra [10] = '{`SLE_CTRL, `SLE_STAT, `SLE_VOUT, `SLE_VIN,
      `SLE_TDLY, `SLE_COSEL, `SLE_E0CFG, `SLE_E1DLY, 12'h100, 12'h400};
   logic [10:0] prg [42] = '{{4'h1, 7'h02}, {4'hB, 7'h00}, {4'h1, 7'h0B},
      {4'hB, 7'h01}, {4'h1, 7'h12}, {4'h3, 7'h1F}, {4'hB, 7'h02},
      {4'h1, 7'h16}, {4'h5, 7'h1A}, {4'hB, 7'h03}, {4'h1, 7'h22},
      {4'h7, 7'h2E}, {4'hB, 7'h04}, {4'h1, 7'h3C}, {4'hB, 7'h07},
      {4'h2, 7'h24}, {4'h3, 7'h25}, {4'hB, 7'h06}, {4'h1, 7'h2F},
      {4'h5, 7'h3E}, {4'h4, 7'h30}, {4'hB, 7'h08}, {4'h1, 7'h32},
      {4'h8, 7'h00}, {4'h1, 7'h31}, {4'h9, 7'h00}, {4'hB, 7'h09},
      {4'h1, 7'h26}, {4'hB, 7'h0A}, {4'h1, 7'h29}, {4'hB, 7'h0B},
      {4'h1, 7'h2C}, {4'hB, 7'h0C}, {4'h1, 7'h33}, {4'hA, 7'h00},
      {4'hB, 7'h0D}, {4'h1, 7'h00}, {4'h6, 7'h34}, {4'hB, 7'h0E},
      {4'h1, 7'h2A}, {4'hB, 7'h05}, {4'h0, 7'h00}};
   sle_top #(.P_PASS_CYCLES(200)) u_sle_top (
      .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
      .o_hrdata(hrdata), .o_hresp(hresp), .i_cin(cin),
      .i_cout_volt(volt), .i_cout_curr(curr), .i_din(din),
      .i_elem_qty(qty), .i_elem_force_blk(fblk), .o_vout(vout),
      .o_vin(vin), .o_cout_drive(drv), .o_pass_done(done));
   sle_contact_model u_sle_contact_model (.i_clk(clk), .i_drive(drv),
      .i_wet(wet), .i_load(load), .o_volt(volt), .o_curr(curr));
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic end_sim();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one single word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [11:0] a,
         input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // expected flags of one pass, in program order except ev[7] and ev[5]
   task automatic model();
      logic b0;
      b0 = fblk[0] | cin[1];
      ev[7] = ev[6];
      ev[0] = cin[0];
      ev[1] = ~cin[1];
      ev[2] = (wet[0] & ~cin[0]) & ~(load[1] & cin[1]);
      ev[3] = ~(wet[0] & ~cin[0]) | (load[0] & cin[0]);
      ev[4] = din[0] ^ v[0];
      ev[6] = ~din[2] & din[3];
      ev[8] = (v[1] | ev[8]) & ~v[2];
      lat = ~v[4] & (v[3] | lat);
      ev[9] = lat;
      ev[10] = (qty[15:0] > 16'h8000) & ~b0;
      // operate flag read in this pass is the state left by the last one
      ev[5] = eop;
      if (ev[10]) begin
         erc = 0;
         eop = eop | (epc >= 1);
         epc = (epc >= 1) ? epc : epc + 1;
      end else begin
         epc = 0;
         if (eop) begin
            eop = (erc < 1);
            erc = eop ? erc + 1 : 0;
         end
      end
      ev[11] = ~((qty[31:16] < 16'h4000) & ~fblk[1]);
      ev[12] = b0;
      ev[13] = v[5] & (tcnt >= 2);
      tcnt = v[5] ? ((tcnt < 2) ? tcnt + 1 : 2) : 0;
      ev[14] = ~v[6];
   endtask
   // hang guard and count of finished passes
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (done === 1'b1)
         dcnt <= dcnt + 1;
      if (cyc == 20000) begin
         num_errors++;
         end_sim();
      end
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 32'h0);
         chk("rst", rd, (ra[i] == `SLE_E0CFG) ? 32'h0000FFFF : 32'h0);
      end
      foreach (prg[i])
         bus(1'b1, 12'h400 + 12'(4 * i), {21'h0, prg[i]});
      bus(1'b1, `SLE_TDLY, 32'h2);
      bus(1'b1, `SLE_COSEL, 32'h05040302);
      bus(1'b1, `SLE_BSEL, 32'h83);
      bus(1'b1, `SLE_E0CFG, 32'h8000);
      bus(1'b1, `SLE_E1CFG, 32'h14000);
      bus(1'b1, `SLE_E0DLY, 32'h0101);
      // random inputs, boundary quantities first, one pass each
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         v = seed[31:24];
         cin <= seed[7:0];
         din <= seed[11:8];
         wet <= seed[15:12];
         load <= seed[19:16];
         fblk <= seed[21:20] & {2{seed[22]}};
         qty <= (i == 0) ? 32'h40008000 : (i == 1) ? 32'h3FFF8001 : lfsr(seed);
         bus(1'b1, `SLE_VIN, {24'h0, v});
         repeat (3) @(posedge clk);
         model();
         bus(1'b1, `SLE_CTRL, 32'h2);
         n = 0;
         while (done !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
         end
         chk("done", {31'h0, done}, 32'h1);
         chk("vout", {16'h0, vout}, {16'h0, ev});
         chk("vin", {24'h0, vin}, {24'h0, v});
         bus(1'b0, `SLE_CIN, 32'h0);
         chk("cin", rd, {24'h0, cin});
         chk("drive", {28'h0, drv}, {28'h0, cin[3:0]});
         bus(1'b0, `SLE_VOUT, 32'h0);
         chk("vout_rd", rd, {16'h0, ev});
      end
      // software write to the virtual outputs has no effect
      bus(1'b1, `SLE_VOUT, 32'hFFFF);
      bus(1'b0, `SLE_VOUT, 32'h0);
      chk("vout_wr", rd, {16'h0, ev});
      // periodic passes, at least four per system cycle
      bus(1'b1, `SLE_CTRL, 32'h1);
      n = dcnt;
      repeat (900) @(posedge clk);
      chk("rate", {31'h0, (dcnt - n) >= 4}, 32'h1);
      bus(1'b1, `SLE_CTRL, 32'h0);
      repeat (200) @(posedge clk);
      bus(1'b0, `SLE_PCNT, 32'h0);
      chk("pcnt", rd, 32'(dcnt));
      end_sim();
   end
endmodule
bind sle_top sle_top_monitor #(.P_AW(P_AW)) u_sle_top_monitor (
   .i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
   .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
   .o_hresp(o_hresp), .o_vout(o_vout), .o_vin(o_vin),
   .o_pass_done(o_pass_done));
